// File: common/channel_quality_pkg.sv
// constants, register map and field layout of the channel quality monitor
package channel_quality_pkg;

    // timing
    localparam int unsigned CLK_PERIOD_NS    = 20;
    localparam int unsigned SNAP_PERIOD_NS   = 1_000_000;
    localparam int unsigned SNAP_SYMBOLS     = 125_000;
    localparam int unsigned SNAP_CYCLES_CALC = SNAP_PERIOD_NS / CLK_PERIOD_NS;

    // widths
    localparam int unsigned SAMPLE_W = 9;
    localparam int unsigned ERR_W    = 8;
    localparam int unsigned FILT_W   = 13;
    localparam int unsigned MSE_W    = 9;
    localparam int unsigned QI_W     = 3;
    localparam int unsigned DATA_W   = 16;
    localparam int unsigned ADDR_W   = 5;
    localparam int unsigned PAIRS    = 4;
    localparam int unsigned THR_N    = 7;

    // slicer reference levels
    localparam logic signed [SAMPLE_W-1:0] LEVEL_HI    = 9'sh080;
    localparam logic signed [SAMPLE_W-1:0] LEVEL_MID   = 9'sh040;
    localparam logic signed [SAMPLE_W-1:0] LEVEL_ZERO  = 9'sh000;
    // compare thresholds
    localparam logic signed [SAMPLE_W-1:0] CMP_FAST    = 9'sh040;
    localparam logic signed [SAMPLE_W-1:0] CMP_GIG_HI  = 9'sh060;
    localparam logic signed [SAMPLE_W-1:0] CMP_GIG_LO  = 9'sh020;
    // error bounds
    localparam logic signed [ERR_W-1:0]    ERR_MAX_GIG  = 8'sh20;
    localparam logic signed [ERR_W-1:0]    ERR_MAX_FAST = 8'sh40;

    localparam logic [MSE_W-1:0] MSE_SAT = 9'h1FF;
    localparam logic [QI_W-1:0]  QI_BEST = 3'h7;

    // register indices
    localparam logic [ADDR_W-1:0] ADDR_CONFIG    = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_MSE       = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_MSE_WORST = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_QUALITY   = 5'h03;
    localparam logic [ADDR_W-1:0] ADDR_MEAN_ERR  = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_THR_BASE  = 5'h08;

    // configuration fields
    localparam int unsigned CFG_ENABLE    = 0;
    localparam int unsigned CFG_SQUARE    = 1;
    localparam int unsigned CFG_UNMAPPED  = 2;
    localparam int unsigned CFG_GAIN_LSB  = 3;
    localparam int unsigned CFG_SCALE_LSB = 7;
    localparam int unsigned CFG_CAPTURE   = 11;
    localparam int unsigned CFG_PAIR_LSB  = 12;
    localparam int unsigned SHIFT_W       = 4;
    localparam int unsigned PAIR_W        = 2;
    localparam int unsigned QI_WORST_LSB  = 4;

    localparam logic [SHIFT_W-1:0] GAIN_RESET  = 4'h4;
    localparam logic [SHIFT_W-1:0] SCALE_RESET = 4'h0;
    localparam logic [MSE_W-1:0]   THR_RESET   = 9'h000;

endpackage : channel_quality_pkg

// File: core/error_slicer.sv
// symbol decision and bounded slicer error for one sample
`timescale 1ns/1ns
module error_slicer
    import channel_quality_pkg::*;
(
    input  wire logic                       gigabit_mode,
    input  wire logic signed [SAMPLE_W-1:0] sample_value,
    output logic signed [SAMPLE_W-1:0]      decision_level,
    output logic signed [ERR_W-1:0]         slicer_error
);

    logic signed [SAMPLE_W:0] raw_error;

    always_comb begin
        if (gigabit_mode) begin
            if (sample_value >= CMP_GIG_HI) begin
                decision_level = LEVEL_HI;
            end else if (sample_value >= CMP_GIG_LO) begin
                decision_level = LEVEL_MID;
            end else if (sample_value >= -CMP_GIG_LO) begin
                decision_level = LEVEL_ZERO;
            end else if (sample_value >= -CMP_GIG_HI) begin
                decision_level = -LEVEL_MID;
            end else begin
                decision_level = -LEVEL_HI;
            end
        end else begin
            if (sample_value >= CMP_FAST) begin
                decision_level = LEVEL_HI;
            end else if (sample_value >= -CMP_FAST) begin
                decision_level = LEVEL_ZERO;
            end else begin
                decision_level = -LEVEL_HI;
            end
        end
        raw_error = 10'(sample_value) - 10'(decision_level);
        if (gigabit_mode && raw_error > 10'(ERR_MAX_GIG)) begin
            slicer_error = ERR_MAX_GIG;
        end else if (gigabit_mode && raw_error < -10'(ERR_MAX_GIG)) begin
            slicer_error = -ERR_MAX_GIG;
        end else if (raw_error > 10'(ERR_MAX_FAST)) begin
            slicer_error = ERR_MAX_FAST;
        end else if (raw_error < -10'(ERR_MAX_FAST)) begin
            slicer_error = -ERR_MAX_FAST;
        end else begin
            slicer_error = raw_error[ERR_W-1:0];
        end
    end

endmodule : error_slicer

// File: core/channel_quality_monitor.sv
// receive channel quality monitor: filter, snapshots, mse and quality index
`timescale 1ns/1ns

// Notes on behaviour
// - slicer levels: -128,0,128 or five-level set
// - decision thresholds +/-64 or -96,-32,32,96
// - slicer error bounded +/-32 gigabit, +/-64 fast
// - filter adds gain-weighted error minus filtered value
// - gigabit doubles absolute error before filtering
// - square mode squares error, else absolute
// - gain field divides add-back by power of two
// - mse is filtered shifted, saturated at 511
// - filtered value snapshotted every millisecond
// - capture bit self-clears, posts selected pair result
// - worst mse kept, restarted by mse read
// - seven thresholds map mse to index 0-7
// - mapped capture posts quality index
// - lowest index since last read reported
// - unmapped capture posts filtered slicer error
module channel_quality_monitor
    import channel_quality_pkg::*;
#(
    parameter int unsigned SNAP_CYCLES = SNAP_CYCLES_CALC
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       sample_valid,
    input  wire logic signed [SAMPLE_W-1:0] sample_value,
    input  wire logic [PAIR_W-1:0]          sample_pair,
    input  wire logic                       gigabit_mode,
    input  wire logic [ADDR_W-1:0]          reg_addr,
    input  wire logic [DATA_W-1:0]          reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [DATA_W-1:0]               reg_rdata,
    output logic signed [SAMPLE_W-1:0]      decision_level,
    output logic                            decision_valid
);

    if (SNAP_CYCLES < 2 || SNAP_CYCLES > 32'h00FF_FFFF) begin : g_check
        $error("SNAP_CYCLES out of range");
    end

    function automatic logic is_thr(input logic [ADDR_W-1:0] a);
        return a >= ADDR_THR_BASE && a < ADDR_THR_BASE + ADDR_W'(THR_N);
    endfunction : is_thr

    function automatic logic [MSE_W-1:0] scale_mse(input logic [FILT_W-1:0] v,
                                                   input logic [SHIFT_W-1:0] s);
        logic [FILT_W-1:0] q;
        q = v >> s;
        return (q > FILT_W'(MSE_SAT)) ? MSE_SAT : q[MSE_W-1:0];
    endfunction : scale_mse

    // ---------------- configuration ----------------
    logic                   enable, square_mode, unmapped_mode;
    logic [SHIFT_W-1:0]     filter_gain_shift, output_scale_shift;
    logic [PAIR_W-1:0]      pair_select;
    logic [MSE_W-1:0]       thr [THR_N];
    logic                   next_enable, next_square_mode, next_unmapped_mode;
    logic [SHIFT_W-1:0]     next_filter_gain_shift, next_output_scale_shift;
    logic [PAIR_W-1:0]      next_pair_select;
    logic [MSE_W-1:0]       next_thr [THR_N];
    logic                   capture_request;

    always_comb begin
        next_enable             = enable;
        next_square_mode        = square_mode;
        next_unmapped_mode      = unmapped_mode;
        next_filter_gain_shift  = filter_gain_shift;
        next_output_scale_shift = output_scale_shift;
        next_pair_select        = pair_select;
        next_thr                = thr;
        capture_request         = 1'b0;
        if (reg_wr && reg_addr == ADDR_CONFIG) begin
            next_enable             = reg_wdata[CFG_ENABLE];
            next_square_mode        = reg_wdata[CFG_SQUARE];
            next_unmapped_mode      = reg_wdata[CFG_UNMAPPED];
            next_filter_gain_shift  = reg_wdata[CFG_GAIN_LSB +: SHIFT_W];
            next_output_scale_shift = reg_wdata[CFG_SCALE_LSB +: SHIFT_W];
            next_pair_select        = reg_wdata[CFG_PAIR_LSB +: PAIR_W];
            capture_request         = reg_wdata[CFG_CAPTURE];
        end else if (reg_wr && is_thr(reg_addr)) begin
            next_thr[3'(reg_addr - ADDR_THR_BASE)] = reg_wdata[MSE_W-1:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            enable             <= 1'b0;
            square_mode        <= 1'b0;
            unmapped_mode      <= 1'b0;
            filter_gain_shift  <= GAIN_RESET;
            output_scale_shift <= SCALE_RESET;
            pair_select        <= '0;
            for (int i = 0; i < THR_N; i++) begin
                thr[i] <= THR_RESET;
            end
        end else begin
            enable             <= next_enable;
            square_mode        <= next_square_mode;
            unmapped_mode      <= next_unmapped_mode;
            filter_gain_shift  <= next_filter_gain_shift;
            output_scale_shift <= next_output_scale_shift;
            pair_select        <= next_pair_select;
            thr                <= next_thr;
        end
    end

    function automatic logic [QI_W-1:0] quality_of(input logic [MSE_W-1:0] m,
                                                   input logic [MSE_W-1:0] t [THR_N]);
        logic [QI_W-1:0] q;
        q = '0;
        for (int k = 0; k < THR_N; k++) begin
            if (m <= t[k]) begin
                q = QI_W'(k + 1);
            end
        end
        return q;
    endfunction : quality_of

    // ---------------- slicer and conditioning ----------------
    logic signed [SAMPLE_W-1:0] level_now;
    logic signed [ERR_W-1:0]    error_now;
    logic [ERR_W-1:0]           abs_error, scaled_error;
    logic [FILT_W-1:0]          conditioned;

    error_slicer u_slicer (
        .gigabit_mode   (gigabit_mode),
        .sample_value   (sample_value),
        .decision_level (level_now),
        .slicer_error   (error_now)
    );

    always_comb begin
        abs_error    = error_now[ERR_W-1] ? ERR_W'(-error_now) : ERR_W'(error_now);
        scaled_error = gigabit_mode ? ERR_W'(abs_error << 1) : abs_error;
        if (square_mode) begin
            conditioned = FILT_W'(scaled_error * scaled_error);
        end else begin
            conditioned = FILT_W'(scaled_error);
        end
    end

    // ---------------- filters, snapshots and worst values per pair ----------------
    logic [FILT_W-1:0] filt [PAIRS];
    logic [FILT_W-1:0] snap [PAIRS];
    logic [MSE_W-1:0]  worst_mse [PAIRS];
    logic [QI_W-1:0]   worst_qi [PAIRS];
    logic [23:0]       snap_cnt;
    logic [FILT_W-1:0] next_filt [PAIRS];
    logic [FILT_W-1:0] next_snap [PAIRS];
    logic [MSE_W-1:0]  next_worst_mse [PAIRS];
    logic [QI_W-1:0]   next_worst_qi [PAIRS];
    logic [23:0]       next_snap_cnt;
    logic              snap_tick;
    logic [PAIR_W-1:0] result_pair;
    logic              mse_read, qi_read;

    always_comb begin
        logic signed [FILT_W:0] diff;
        logic [MSE_W-1:0]       m;
        logic [QI_W-1:0]        q;
        diff           = '0;
        m              = '0;
        q              = '0;
        next_filt      = filt;
        next_snap      = snap;
        next_worst_mse = worst_mse;
        next_worst_qi  = worst_qi;
        snap_tick      = snap_cnt == 24'(SNAP_CYCLES - 1);
        next_snap_cnt  = snap_tick ? '0 : snap_cnt + 24'h000001;
        mse_read       = reg_rd && reg_addr == ADDR_MSE;
        qi_read        = reg_rd && reg_addr == ADDR_QUALITY;
        for (int p = 0; p < PAIRS; p++) begin
            if (enable && sample_valid && sample_pair == PAIR_W'(p)) begin
                diff = $signed({1'b0, conditioned}) - $signed({1'b0, filt[p]});
                next_filt[p] = FILT_W'($signed({1'b0, filt[p]})
                                        + (diff >>> filter_gain_shift));
            end
            if (mse_read && result_pair == PAIR_W'(p)) begin
                next_worst_mse[p] = '0;
            end
            if (qi_read && result_pair == PAIR_W'(p)) begin
                next_worst_qi[p] = QI_BEST;
            end
            if (snap_tick && enable) begin
                next_snap[p] = filt[p];
                m = scale_mse(filt[p], output_scale_shift);
                q = quality_of(m, thr);
                if (m > next_worst_mse[p]) begin
                    next_worst_mse[p] = m;
                end
                if (q < next_worst_qi[p]) begin
                    next_worst_qi[p] = q;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            snap_cnt <= '0;
            for (int p = 0; p < PAIRS; p++) begin
                filt[p]      <= '0;
                snap[p]      <= '0;
                worst_mse[p] <= '0;
                worst_qi[p]  <= QI_BEST;
            end
        end else begin
            snap_cnt  <= next_snap_cnt;
            filt      <= next_filt;
            snap      <= next_snap;
            worst_mse <= next_worst_mse;
            worst_qi  <= next_worst_qi;
        end
    end

    // ---------------- captured results ----------------
    logic [MSE_W-1:0]  mse_result, next_mse_result;
    logic [QI_W-1:0]   qi_result, next_qi_result;
    logic [FILT_W-1:0] mean_error, next_mean_error;
    logic [PAIR_W-1:0] next_result_pair;
    logic [MSE_W-1:0]  cap_mse;

    always_comb begin
        next_result_pair = result_pair;
        next_mse_result  = mse_result;
        next_qi_result   = qi_result;
        next_mean_error  = mean_error;
        cap_mse          = scale_mse(snap[next_pair_select], next_output_scale_shift);
        if (capture_request) begin
            next_result_pair = next_pair_select;
            next_mse_result  = cap_mse;
            if (next_unmapped_mode) begin
                next_mean_error = snap[next_pair_select];
            end else begin
                next_qi_result = quality_of(cap_mse, thr);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            result_pair <= '0;
            mse_result  <= '0;
            qi_result   <= '0;
            mean_error  <= '0;
        end else begin
            result_pair <= next_result_pair;
            mse_result  <= next_mse_result;
            qi_result   <= next_qi_result;
            mean_error  <= next_mean_error;
        end
    end

    // ---------------- decision output and read port ----------------
    logic [DATA_W-1:0] next_reg_rdata;
    logic [QI_W-1:0]   qi_worst_view;

    always_comb begin
        qi_worst_view  = (qi_result < worst_qi[result_pair]) ? qi_result
                                                             : worst_qi[result_pair];
        next_reg_rdata = '0;
        if (!reg_rd) begin
            next_reg_rdata = '0;
        end else if (reg_addr == ADDR_CONFIG) begin
            next_reg_rdata[CFG_ENABLE]                  = enable;
            next_reg_rdata[CFG_SQUARE]                  = square_mode;
            next_reg_rdata[CFG_UNMAPPED]                = unmapped_mode;
            next_reg_rdata[CFG_GAIN_LSB +: SHIFT_W]     = filter_gain_shift;
            next_reg_rdata[CFG_SCALE_LSB +: SHIFT_W]    = output_scale_shift;
            next_reg_rdata[CFG_PAIR_LSB +: PAIR_W]      = pair_select;
        end else if (reg_addr == ADDR_MSE) begin
            next_reg_rdata[MSE_W-1:0] = mse_result;
        end else if (reg_addr == ADDR_MSE_WORST) begin
            next_reg_rdata[MSE_W-1:0] = (mse_result > worst_mse[result_pair])
                                        ? mse_result : worst_mse[result_pair];
        end else if (reg_addr == ADDR_QUALITY) begin
            next_reg_rdata[QI_W-1:0]                = qi_result;
            next_reg_rdata[QI_WORST_LSB +: QI_W]    = qi_worst_view;
        end else if (reg_addr == ADDR_MEAN_ERR) begin
            next_reg_rdata[FILT_W-1:0] = mean_error;
        end else if (is_thr(reg_addr)) begin
            next_reg_rdata[MSE_W-1:0] = thr[3'(reg_addr - ADDR_THR_BASE)];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata      <= '0;
            decision_level <= '0;
            decision_valid <= 1'b0;
        end else begin
            reg_rdata      <= next_reg_rdata;
            decision_level <= level_now;
            decision_valid <= sample_valid;
        end
    end

endmodule : channel_quality_monitor

// File: verification/channel_quality_monitor_chk.sv
// port assertions for the channel quality monitor
`timescale 1ns/1ns
module channel_quality_monitor_chk
    import channel_quality_pkg::*;
#(
    parameter int unsigned SNAP_CYCLES = 16
) (
    input wire logic                       core_clk,
    input wire logic                       rst,
    input wire logic                       sample_valid,
    input wire logic signed [SAMPLE_W-1:0] sample_value,
    input wire logic                       gigabit_mode,
    input wire logic [ADDR_W-1:0]          reg_addr,
    input wire logic                       reg_rd,
    input wire logic [DATA_W-1:0]          reg_rdata,
    input wire logic signed [SAMPLE_W-1:0] decision_level
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic fast_v;
    logic gig_v;
    assign fast_v = sample_valid && !gigabit_mode;
    assign gig_v  = sample_valid && gigabit_mode;

    chk_fast_outer:
    assert property (fast_v && (sample_value >= CMP_FAST || sample_value < -CMP_FAST)
        |=> decision_level == ($past(sample_value) >= 0 ? LEVEL_HI : -LEVEL_HI))
        else $error("fast outer level wrong");
    chk_fast_mid:
    assert property (fast_v && sample_value < CMP_FAST && sample_value >= -CMP_FAST
        |=> decision_level == LEVEL_ZERO) else $error("fast middle level wrong");
    chk_gig_outer:
    assert property (gig_v && (sample_value >= CMP_GIG_HI || sample_value < -CMP_GIG_HI)
        |=> decision_level == ($past(sample_value) >= 0 ? LEVEL_HI : -LEVEL_HI))
        else $error("gigabit outer level wrong");
    chk_gig_pos:
    assert property (gig_v && sample_value >= CMP_GIG_LO && sample_value < CMP_GIG_HI
        |=> decision_level == LEVEL_MID) else $error("gigabit upper mid level wrong");
    chk_gig_neg:
    assert property (gig_v && sample_value < -CMP_GIG_LO && sample_value >= -CMP_GIG_HI
        |=> decision_level == -LEVEL_MID) else $error("gigabit lower mid level wrong");
    chk_gig_zero:
    assert property (gig_v && sample_value >= -CMP_GIG_LO && sample_value < CMP_GIG_LO
        |=> decision_level == LEVEL_ZERO) else $error("gigabit zero level wrong");
    chk_capture_clear:
    assert property (reg_rd && reg_addr == ADDR_CONFIG |=> !reg_rdata[CFG_CAPTURE])
        else $error("capture bit reads set");
    chk_mse_range:
    assert property (reg_rd && (reg_addr == ADDR_MSE || reg_addr == ADDR_MSE_WORST)
        |=> reg_rdata <= {7'h00, MSE_SAT}) else $error("mse above saturation");
endmodule : channel_quality_monitor_chk

bind channel_quality_monitor channel_quality_monitor_chk #(.SNAP_CYCLES(SNAP_CYCLES)) i_chk (
    .core_clk(core_clk), .rst(rst), .sample_valid(sample_valid),
    .sample_value(sample_value), .gigabit_mode(gigabit_mode), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .decision_level(decision_level)
);

// File: verification/symbol_source.sv
// receive datapath model that feeds bursts of samples
`timescale 1ns/1ns
module symbol_source
    import channel_quality_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       go,
    input  wire logic                       slow,
    input  wire logic [7:0]                 count,
    input  wire logic signed [SAMPLE_W-1:0] value,
    input  wire logic [PAIR_W-1:0]          pair,
    output logic                            busy,
    output logic                            sample_valid,
    output logic signed [SAMPLE_W-1:0]      sample_value,
    output logic [PAIR_W-1:0]               sample_pair
);
    logic [7:0] left;
    logic       gap;
    // idle cycles toggle the value so stale data never looks valid
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {busy, sample_valid, gap, left, sample_pair} <= '0;
            sample_value <= '0;
        end else if (busy && left != 8'h00 && !gap) begin
            sample_valid <= 1'b1;
            sample_value <= value;
            sample_pair  <= pair;
            left         <= left - 8'h01;
            gap          <= slow;
        end else begin
            busy         <= (go && !busy) || (busy && left != 8'h00);
            left         <= (go && !busy) ? count : left;
            gap          <= 1'b0;
            sample_valid <= 1'b0;
            sample_value <= ~sample_value;
        end
    end
endmodule : symbol_source

// File: verification/test_channel_quality_monitor.sv
// self-checking bench for the channel quality monitor
`timescale 1ns/1ns
module test_channel_quality_monitor;
    import channel_quality_pkg::*;
    localparam int unsigned SNAP = 16;
    logic core_clk, rst, gigabit_mode, reg_wr, reg_rd, go, slow, busy;
    logic sample_valid, decision_valid;
    logic signed [SAMPLE_W-1:0] sample_value, decision_level, src_value, last_dec;
    logic [PAIR_W-1:0] sample_pair, src_pair;
    logic [7:0] src_count;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    int err_count, cmp_count, cycles;

    channel_quality_monitor #(.SNAP_CYCLES(SNAP)) i_channel_quality_monitor (
        .core_clk(core_clk), .rst(rst), .sample_valid(sample_valid),
        .sample_value(sample_value), .sample_pair(sample_pair), .gigabit_mode(gigabit_mode),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .decision_level(decision_level), .decision_valid(decision_valid));
    symbol_source i_symbol_source (
        .core_clk(core_clk), .rst(rst), .go(go), .slow(slow), .count(src_count),
        .value(src_value), .pair(src_pair), .busy(busy), .sample_valid(sample_valid),
        .sample_value(sample_value), .sample_pair(sample_pair));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (decision_valid === 1'b1) last_dec <= decision_level;
        if (cycles == 5000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [DATA_W-1:0] exp,
                         input logic [DATA_W-1:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd_check(input string what, input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] exp);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(what, exp, reg_rdata);
    endtask : rd_check

    function automatic logic [DATA_W-1:0] cfg(input logic sq, input logic unm,
        input logic [3:0] gain, input logic [3:0] scale, input logic [1:0] pair);
        cfg = {2'h0, pair, 1'b0, scale, gain, unm, sq, 1'b1};
    endfunction : cfg

    task automatic cap(input logic [DATA_W-1:0] c);
        wr(ADDR_CONFIG, c | (16'h0001 << CFG_CAPTURE));
    endtask : cap

    task automatic send(input logic signed [SAMPLE_W-1:0] v, input logic [PAIR_W-1:0] p,
                        input logic [7:0] n);
        int k;
        k = 0;
        @(posedge core_clk);
        {go, src_value, src_pair, src_count} <= {1'b1, v, p, n};
        @(posedge core_clk);
        go <= 1'b0;
        @(negedge core_clk);
        while (busy === 1'b1 && k < 600) begin
            @(negedge core_clk);
            k++;
        end
    endtask : send

    task automatic t_reset();
        wr(5'h1F, 16'hFFFF);
        rd_check("unmapped", 5'h1F, 16'h0000);
        rd_check("config", ADDR_CONFIG, {9'h000, GAIN_RESET, 3'h0});
        rd_check("quality", ADDR_QUALITY, 16'h0000);
        rd_check("threshold", ADDR_THR_BASE, 16'h0000);
        $display("reset test done");
    endtask : t_reset

    task automatic t_slicer();
        int tv [13][3] = '{'{0, 64, 128}, '{0, 63, 0}, '{0, -64, 0}, '{0, -65, -128},
            '{0, 0, 0}, '{1, 96, 128}, '{1, 95, 64}, '{1, 32, 64}, '{1, 31, 0},
            '{1, -32, 0}, '{1, -33, -64}, '{1, -96, -64}, '{1, -97, -128}};
        foreach (tv[i]) begin
            gigabit_mode <= tv[i][0][0];
            slow         <= tv[i][0][0];
            last_dec = '1;
            send(SAMPLE_W'(tv[i][1]), 2'h3, 8'h01);
            repeat (2) @(posedge core_clk);
            check("decision", DATA_W'(tv[i][2]), DATA_W'(last_dec));
        end
        $display("slicer test done");
    endtask : t_slicer

    task automatic t_filter();
        logic [DATA_W-1:0] thr [7] = '{16'd200, 16'd100, 16'd50, 16'd30, 16'd20, 16'd10, 16'd5};
        foreach (thr[k]) wr(ADDR_W'(ADDR_THR_BASE + k), thr[k]);
        gigabit_mode <= 1'b0;
        rd_check("top threshold", ADDR_THR_BASE + 5'h06, 16'h0005);
        wr(ADDR_CONFIG, cfg('0, '0, '0, '0, '0));
        send(9'sd20, 2'h1, 8'd3);
        wr(ADDR_CONFIG, cfg('0, '0, 4'h1, '0, '0));
        send(9'sd20, 2'h2, 8'd2);
        repeat (SNAP + 4) @(posedge core_clk);
        cap(cfg('0, '0, 4'h1, '0, 2'h1));
        rd_check("mse pair 1", ADDR_MSE, 16'd20);
        rd_check("index pair 1", ADDR_QUALITY, 16'h0055);
        rd_check("config", ADDR_CONFIG, cfg('0, '0, 4'h1, '0, 2'h1));
        cap(cfg('0, '0, 4'h1, '0, 2'h2));
        rd_check("mse gain one", ADDR_MSE, 16'd15);
        cap(cfg('0, '0, 4'h1, '0, 2'h3));
        rd_check("mse disabled pair", ADDR_MSE, 16'd0);
        $display("filter test done");
    endtask : t_filter

    task automatic t_worst();
        cap(cfg('0, '0, '0, '0, '0));
        rd_check("mse pair 0", ADDR_MSE, 16'd0);
        rd_check("quality pair 0", ADDR_QUALITY, 16'h0077);
        send(9'sd200, 2'h0, 8'd1);
        repeat (SNAP + 4) @(posedge core_clk);
        send(9'sd20, 2'h0, 8'd1);
        repeat (SNAP + 4) @(posedge core_clk);
        cap(cfg('0, '0, '0, '0, '0));
        rd_check("worst mse", ADDR_MSE_WORST, 16'd64);
        rd_check("mse", ADDR_MSE, 16'd20);
        rd_check("worst index", ADDR_QUALITY, 16'h0025);
        repeat (SNAP + 4) @(posedge core_clk);
        rd_check("worst restarted", ADDR_MSE_WORST, 16'd20);
        $display("worst test done");
    endtask : t_worst

    task automatic t_square();
        wr(ADDR_CONFIG, cfg('1, '0, '0, '0, 2'h1));
        gigabit_mode <= 1'b1;
        send(9'sd10, 2'h1, 8'd1);
        repeat (SNAP + 4) @(posedge core_clk);
        cap(cfg('1, '0, '0, '0, 2'h1));
        rd_check("square mse", ADDR_MSE, 16'd400);
        send(9'sd30, 2'h1, 8'd1);
        repeat (SNAP + 4) @(posedge core_clk);
        cap(cfg('1, '0, '0, '0, 2'h1));
        rd_check("saturated mse", ADDR_MSE, 16'd511);
        cap(cfg('1, '0, '0, 4'h3, 2'h1));
        rd_check("scaled mse", ADDR_MSE, 16'd450);
        cap(cfg('1, '1, '0, 4'h3, 2'h1));
        rd_check("mean error", ADDR_MEAN_ERR, 16'd3600);
        $display("square test done");
    endtask : t_square

    initial begin
        {rst, gigabit_mode, reg_wr, reg_rd, go, slow} = 6'b100000;
        {reg_addr, reg_wdata, src_value, src_pair, src_count} = '0;
        {err_count, cmp_count, cycles} = '0;
        last_dec = '0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_slicer();
        t_filter();
        t_worst();
        t_square();
        give_verdict();
    end
endmodule : test_channel_quality_monitor
